//--- rtl/hcd_pkg.sv
// Package: register map, field layout and carrier types of the divider parameter bank
//
// Notes on behaviour
// [R1] Post divider code n divides by 2^n
// [R2] Integer parameter is an 18-bit value
// [R3] Integer bits from offsets 76, 77, 78
// [R4] Numerator nibble 79[3:0], bytes 80, 81
// [R5] Denominator nibble 79[7:4], low byte 75
// [R6] Fifth denominator bytes at offsets 82, 83
// [R7] Contents undefined; software programs before use
// [R8] Fourth denominator middle byte at offset 74
// [R9] Fifth denominator nibble from 87[7:4]
// [R10] Offset 76 bits 7,3:2 read zero
package hcd_pkg;

   // ------------------------------------------------------------
   // Bus geometry and answers
   // ------------------------------------------------------------
   localparam int         ADDR_W      = 9;
   localparam int         IDX_W       = 7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [6:0] IDX_DEN4_MID  = 7'h4a;
   localparam logic [6:0] IDX_DEN4_LOW  = 7'h4b;
   localparam logic [6:0] IDX_PDIV_INT  = 7'h4c;
   localparam logic [6:0] IDX_INT_MID   = 7'h4d;
   localparam logic [6:0] IDX_INT_LOW   = 7'h4e;
   localparam logic [6:0] IDX_FRAC_HI   = 7'h4f;
   localparam logic [6:0] IDX_NUM_MID   = 7'h50;
   localparam logic [6:0] IDX_NUM_LOW   = 7'h51;
   localparam logic [6:0] IDX_DEN5_MID  = 7'h52;
   localparam logic [6:0] IDX_DEN5_LOW  = 7'h53;
   localparam logic [6:0] IDX_DEN5_HI   = 7'h57;

   // ------------------------------------------------------------
   // Storage slots, in the order of the index table
   // ------------------------------------------------------------
   localparam int NREG        = 11;
   localparam int SL_DEN4_MID = 0;
   localparam int SL_DEN4_LOW = 1;
   localparam int SL_PDIV_INT = 2;
   localparam int SL_INT_MID  = 3;
   localparam int SL_INT_LOW  = 4;
   localparam int SL_FRAC_HI  = 5;
   localparam int SL_NUM_MID  = 6;
   localparam int SL_NUM_LOW  = 7;
   localparam int SL_DEN5_MID = 8;
   localparam int SL_DEN5_LOW = 9;
   localparam int SL_DEN5_HI  = 10;

   localparam logic [6:0] REG_IDX [NREG] = '{
      IDX_DEN4_MID, IDX_DEN4_LOW, IDX_PDIV_INT, IDX_INT_MID, IDX_INT_LOW, IDX_FRAC_HI,
      IDX_NUM_MID, IDX_NUM_LOW, IDX_DEN5_MID, IDX_DEN5_LOW, IDX_DEN5_HI};

   // ------------------------------------------------------------
   // Field layout, writable masks and reset values
   // ------------------------------------------------------------
   localparam int         PDIV_MSB    = 6;
   localparam int         PDIV_LSB    = 4;
   localparam int         INT_HI_MSB  = 1;
   localparam int         NUM_HI_MSB  = 3;
   localparam int         DEN_HI_MSB  = 7;
   localparam int         DEN_HI_LSB  = 4;
   localparam logic [7:0] MASK_FULL   = 8'hff;
   localparam logic [7:0] MASK_PDIV   = 8'h73;
   localparam logic [7:0] PARAM_RESET = 8'h00;
   localparam logic [7:0] RATIO_ONE   = 8'h01;

   localparam logic [7:0] REG_MASK [NREG] = '{
      MASK_FULL, MASK_FULL, MASK_PDIV, MASK_FULL, MASK_FULL, MASK_FULL,
      MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};

   // ------------------------------------------------------------
   // Carrier toward the divider datapath
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  post_divider_select;
      logic [17:0] div4_integer_param;
      logic [19:0] div4_numerator_param;
      logic [19:0] div4_denominator_param;
      logic [19:0] div5_denominator_param;
   } hcd_div_cfg_t;

endpackage

//--- rtl/hcd_byte_reg.sv
// One byte-wide parameter register with a mask of writable bits
`timescale 1ns/100ps
module hcd_byte_reg #(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] RST  = 8'h00
) (
   input  wire  logic       aclk,     // Bus clock
   input  wire  logic       aresetn,  // Synchronous reset, active low
   input  wire  logic       wr_en,    // Store strobe
   input  wire  logic [7:0] wr_data,  // Byte to store
   output logic       [7:0] q         // Stored byte
);
   logic [7:0] q_d;

   always_comb begin
      q_d = q;
      if (wr_en) begin
         q_d = wr_data & MASK;  // [R10]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else begin
         q <= q_d;
      end
   end
endmodule

//--- rtl/hcd_param_regs.sv
// AXI4-Lite register bank holding the fourth and fifth divider parameters
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module hcd_param_regs (
   input  wire  logic                      aclk,               // Bus clock
   input  wire  logic                      aresetn,            // Synchronous reset, active low
   input  wire  logic [hcd_pkg::ADDR_W-1:0] awaddr,            // Write address
   input  wire  logic                      awvalid,            // Write address valid
   output logic                            awready,            // Write address ready
   input  wire  logic [31:0]               wdata,              // Write data
   input  wire  logic [3:0]                wstrb,              // Write byte enables
   input  wire  logic                      wvalid,             // Write data valid
   output logic                            wready,             // Write data ready
   output logic [1:0]                      bresp,              // Write response
   output logic                            bvalid,             // Write response valid
   input  wire  logic                      bready,             // Write response ready
   input  wire  logic [hcd_pkg::ADDR_W-1:0] araddr,            // Read address
   input  wire  logic                      arvalid,            // Read address valid
   output logic                            arready,            // Read address ready
   output logic [31:0]                     rdata,              // Read data
   output logic [1:0]                      rresp,              // Read response
   output logic                            rvalid,             // Read data valid
   input  wire  logic                      rready,             // Read data ready
   output hcd_pkg::hcd_div_cfg_t           cfg,                // Fields toward the dividers
   output logic [7:0]                      post_divide_ratio   // Decoded post divide ratio
);
   import hcd_pkg::*;

   // ------------------------------------------------------------
   // Bus state
   // ------------------------------------------------------------
   logic                    awready_q, awready_d;
   logic                    wready_q, wready_d;
   logic                    aw_full_q, aw_full_d;
   logic                    w_full_q, w_full_d;
   logic [IDX_W-1:0]        aw_idx_q, aw_idx_d;
   logic [7:0]              w_byte_q, w_byte_d;
   logic                    w_lane_q, w_lane_d;
   logic                    bvalid_q, bvalid_d;
   logic [1:0]              bresp_q, bresp_d;
   logic                    arready_q, arready_d;
   logic                    rvalid_q, rvalid_d;
   logic [31:0]             rdata_q, rdata_d;
   logic [1:0]              rresp_q, rresp_d;
   logic [7:0]              ratio_q, ratio_d;

   logic                    aw_take, w_take, ar_take, do_write;
   logic                    wr_hit, rd_hit;
   logic [IDX_W-1:0]        ar_idx;
   logic [7:0]              rd_byte;
   logic [NREG-1:0]         wr_sel;
   logic [7:0]              q [NREG];

   assign aw_take  = awvalid && awready_q;
   assign w_take   = wvalid && wready_q;
   assign ar_take  = arvalid && arready_q;
   // Address and data may arrive in either order; store once both are held
   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign ar_idx   = araddr[ADDR_W-1:2];

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   // Only byte lane 0 carries data; upper lanes hold nothing
   generate
      for (genvar i = 0; i < NREG; i++) begin : g_reg
         assign wr_sel[i] = do_write && w_lane_q && (aw_idx_q == REG_IDX[i]);
         hcd_byte_reg #(
            .MASK (REG_MASK[i]),
            .RST  (PARAM_RESET)
         ) u_reg (
            .aclk    (aclk),
            .aresetn (aresetn),
            .wr_en   (wr_sel[i]),
            .wr_data (w_byte_q),
            .q       (q[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   always_comb begin
      wr_hit  = 1'b0;
      rd_hit  = 1'b0;
      rd_byte = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (aw_idx_q == REG_IDX[i]) begin
            wr_hit = 1'b1;
         end
         if (ar_idx == REG_IDX[i]) begin
            rd_hit  = 1'b1;
            rd_byte = q[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   always_comb begin
      aw_full_d = aw_full_q || aw_take;
      w_full_d  = w_full_q || w_take;
      aw_idx_d  = aw_take ? awaddr[ADDR_W-1:2] : aw_idx_q;
      w_byte_d  = w_take ? wdata[7:0] : w_byte_q;
      w_lane_d  = w_take ? wstrb[0] : w_lane_q;
      bvalid_d  = bvalid_q && !bready;
      bresp_d   = bresp_q;
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // Hold both channels off until the response is taken
      awready_d = !aw_full_d && !bvalid_d;
      wready_d  = !w_full_d && !bvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_idx_q  <= '0;
         w_byte_q  <= 8'h00;
         w_lane_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         aw_idx_q  <= aw_idx_d;
         w_byte_q  <= w_byte_d;
         w_lane_q  <= w_lane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   always_comb begin
      rvalid_d  = rvalid_q && !rready;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (ar_take) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, rd_byte};  // [R10]
         rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // ------------------------------------------------------------
   // Field assembly toward the divider datapath
   // ------------------------------------------------------------
   // Reset zeros only give a known start; software programs all fields first
   assign cfg.post_divider_select    = q[SL_PDIV_INT][PDIV_MSB:PDIV_LSB];     // [R1]
   assign cfg.div4_integer_param     = {q[SL_PDIV_INT][INT_HI_MSB:0],
                                        q[SL_INT_MID], q[SL_INT_LOW]};        // [R2] [R3]
   assign cfg.div4_numerator_param   = {q[SL_FRAC_HI][NUM_HI_MSB:0],
                                        q[SL_NUM_MID], q[SL_NUM_LOW]};        // [R4]
   assign cfg.div4_denominator_param = {q[SL_FRAC_HI][DEN_HI_MSB:DEN_HI_LSB],
                                        q[SL_DEN4_MID], q[SL_DEN4_LOW]};      // [R5] [R8]
   assign cfg.div5_denominator_param = {q[SL_DEN5_HI][DEN_HI_MSB:DEN_HI_LSB],
                                        q[SL_DEN5_MID], q[SL_DEN5_LOW]};      // [R6] [R9]

   // Ratio lags the select field by one cycle to keep the output registered
   always_comb begin
      ratio_d = 8'(RATIO_ONE << cfg.post_divider_select);  // [R1]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ratio_q <= RATIO_ONE;
      end else begin
         ratio_q <= ratio_d;
      end
   end

   assign awready           = awready_q;
   assign wready            = wready_q;
   assign bvalid            = bvalid_q;
   assign bresp             = bresp_q;
   assign arready           = arready_q;
   assign rvalid            = rvalid_q;
   assign rdata             = rdata_q;
   assign rresp             = rresp_q;
   assign post_divide_ratio = ratio_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic wr_lane_ok;
   assign wr_lane_ok = do_write && w_lane_q;

   property p_post_ratio;
      ##1 post_divide_ratio == 8'(RATIO_ONE << $past(cfg.post_divider_select));
   endproperty
   a_post_ratio: assert property (p_post_ratio) else $error("post ratio wrong"); // [R1]

   property p_int_low;
      (wr_lane_ok && aw_idx_q == IDX_INT_LOW) |=> cfg.div4_integer_param[7:0] == $past(w_byte_q);
   endproperty
   a_int_low: assert property (p_int_low) else $error("integer low byte lost"); // [R2]

   property p_int_hi;
      (wr_lane_ok && aw_idx_q == IDX_PDIV_INT) |=>
         cfg.div4_integer_param[17:16] == $past(w_byte_q[1:0]) &&
         cfg.post_divider_select == $past(w_byte_q[6:4]);
   endproperty
   a_int_hi: assert property (p_int_hi) else $error("integer top bits wrong"); // [R3]

   property p_num_mid;
      (wr_lane_ok && aw_idx_q == IDX_NUM_MID) |=>
         cfg.div4_numerator_param[15:8] == $past(w_byte_q);
   endproperty
   a_num_mid: assert property (p_num_mid) else $error("numerator mid byte wrong"); // [R4]

   property p_frac_hi;
      (wr_lane_ok && aw_idx_q == IDX_FRAC_HI) |=>
         cfg.div4_denominator_param[19:16] == $past(w_byte_q[7:4]) &&
         cfg.div4_numerator_param[19:16] == $past(w_byte_q[3:0]);
   endproperty
   a_frac_hi: assert property (p_frac_hi) else $error("fraction nibbles wrong"); // [R5]

   property p_den5_mid;
      (wr_lane_ok && aw_idx_q == IDX_DEN5_MID) |=>
         cfg.div5_denominator_param[15:8] == $past(w_byte_q);
   endproperty
   a_den5_mid: assert property (p_den5_mid) else $error("fifth denominator byte wrong"); // [R6]

   property p_hold;
      !do_write |=> $stable(cfg);
   endproperty
   a_hold: assert property (p_hold) else $error("field changed without a write"); // [R7]

   property p_den4_mid;
      (wr_lane_ok && aw_idx_q == IDX_DEN4_MID) |=>
         cfg.div4_denominator_param[15:8] == $past(w_byte_q);
   endproperty
   a_den4_mid: assert property (p_den4_mid) else $error("fourth denominator mid wrong"); // [R8]

   property p_den5_hi;
      (wr_lane_ok && aw_idx_q == IDX_DEN5_HI) |=>
         cfg.div5_denominator_param[19:16] == $past(w_byte_q[7:4]);
   endproperty
   a_den5_hi: assert property (p_den5_hi) else $error("fifth denominator nibble wrong"); // [R9]

   property p_reserved;
      (ar_take && ar_idx == IDX_PDIV_INT) |=> (rdata[7:0] & ~MASK_PDIV) == 8'h00 && rvalid;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R10]

   property p_wr_resp;
      (aw_take && w_take) |-> ##2 bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");

   property p_int_mid;
      (wr_lane_ok && aw_idx_q == IDX_INT_MID) |=>
         cfg.div4_integer_param[15:8] == $past(w_byte_q);
   endproperty
   a_int_mid: assert property (p_int_mid) else $error("integer mid byte wrong"); // [R3]

   property p_num_low;
      (wr_lane_ok && aw_idx_q == IDX_NUM_LOW) |=>
         cfg.div4_numerator_param[7:0] == $past(w_byte_q);
   endproperty
   a_num_low: assert property (p_num_low) else $error("numerator low byte wrong"); // [R4]

   property p_den4_low;
      (wr_lane_ok && aw_idx_q == IDX_DEN4_LOW) |=>
         cfg.div4_denominator_param[7:0] == $past(w_byte_q);
   endproperty
   a_den4_low: assert property (p_den4_low) else $error("fourth denominator low wrong"); // [R5]

   property p_den5_low;
      (wr_lane_ok && aw_idx_q == IDX_DEN5_LOW) |=>
         cfg.div5_denominator_param[7:0] == $past(w_byte_q);
   endproperty
   a_den5_low: assert property (p_den5_low) else $error("fifth denominator low wrong"); // [R6]

   // Refused writes still answer but must not touch any field
   property p_refused;
      (do_write && !(w_lane_q && wr_hit)) |=> $stable(cfg);
   endproperty
   a_refused: assert property (p_refused) else $error("refused write changed a field");

   c_write:    cover property (bvalid && bready && bresp == RESP_OKAY);
   c_read:     cover property (rvalid && rready && rresp == RESP_OKAY);
   c_unmapped: cover property (rvalid && rresp == RESP_SLVERR);
   c_lane_off: cover property (do_write && !w_lane_q);
endmodule

//--- tb/hcd_param_regs_test.sv
// Self-checking bench for the divider parameter register bank
`timescale 1ns/100ps
module hcd_param_regs_test;
   import hcd_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                aclk;
   logic                aresetn;
   logic [ADDR_W-1:0]   awaddr;
   logic                awvalid;
   logic                awready;
   logic [31:0]         wdata;
   logic [3:0]          wstrb;
   logic                wvalid;
   logic                wready;
   logic [1:0]          bresp;
   logic                bvalid;
   logic                bready;
   logic [ADDR_W-1:0]   araddr;
   logic                arvalid;
   logic                arready;
   logic [31:0]         rdata;
   logic [1:0]          rresp;
   logic                rvalid;
   logic                rready;
   hcd_div_cfg_t        cfg;
   logic [7:0]          post_divide_ratio;
   int                  err_total;
   int                  comparisons;

   // Byte addresses and patterns, one per mapped register
   localparam logic [8:0] MAP_ADDR [11] = '{9'h128, 9'h12c, 9'h130, 9'h134, 9'h138, 9'h13c,
                                            9'h140, 9'h144, 9'h148, 9'h14c, 9'h15c};
   localparam logic [7:0] MAP_DATA [11] = '{8'ha5, 8'h3c, 8'hff, 8'h96, 8'h69, 8'hd2,
                                            8'h5a, 8'hc3, 8'h81, 8'h7e, 8'hb4};

   hcd_param_regs dut (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .awaddr            (awaddr),
      .awvalid           (awvalid),
      .awready           (awready),
      .wdata             (wdata),
      .wstrb             (wstrb),
      .wvalid            (wvalid),
      .wready            (wready),
      .bresp             (bresp),
      .bvalid            (bvalid),
      .bready            (bready),
      .araddr            (araddr),
      .arvalid           (arvalid),
      .arready           (arready),
      .rdata             (rdata),
      .rresp             (rresp),
      .rvalid            (rvalid),
      .rready            (rready),
      .cfg               (cfg),
      .post_divide_ratio (post_divide_ratio)
   );

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Bus and check helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Address and data offered together; each released at its own take
   task automatic axi_write(input logic [8:0] a, input logic [7:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h5a5a5a, d};
      wstrb   <= s;
      wvalid  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [8:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk("cfg after reset", 32'(cfg == '0), 32'h1);
      chk("ratio after reset", 32'(post_divide_ratio), 32'h1);
      chk("bvalid after reset", 32'(bvalid), 32'h0);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_map;
      logic [1:0]  resp;
      logic [31:0] rd;
      for (int i = 0; i < 11; i++) begin
         axi_write(MAP_ADDR[i], MAP_DATA[i], 4'h1, resp);
         chk("write resp", 32'(resp), 32'(RESP_OKAY));
      end
      for (int i = 0; i < 11; i++) begin
         axi_read(MAP_ADDR[i], rd, resp);
         chk("read resp", 32'(resp), 32'(RESP_OKAY));
         chk("read back", rd, {24'h0, (i == 2) ? (MAP_DATA[i] & 8'h73) : MAP_DATA[i]});
      end
      chk("integer", 32'(cfg.div4_integer_param), 32'h39669);
      chk("numerator", 32'(cfg.div4_numerator_param), 32'h25ac3);
      chk("denominator", 32'(cfg.div4_denominator_param), 32'hda53c);
      chk("den5", 32'(cfg.div5_denominator_param), 32'hb817e);
      chk("select", 32'(cfg.post_divider_select), 32'h7);
      chk("ratio", 32'(post_divide_ratio), 32'h80);
   endtask

   // Every select code, with reserved bits set on the way in
   task automatic t_post;
      logic [1:0]  resp;
      logic [31:0] rd;
      for (int n = 0; n < 8; n++) begin
         axi_write(9'h130, {1'b1, 3'(n), 4'b1110}, 4'h1, resp);
         repeat (2) @(posedge aclk);
         #1;
         chk("select code", 32'(cfg.post_divider_select), 32'(n));
         chk("ratio code", 32'(post_divide_ratio), 32'(1 << n));
         chk("int high", 32'(cfg.div4_integer_param[17:16]), 32'h2);
         axi_read(9'h130, rd, resp);
         chk("reserved read", rd, {24'h0, 1'b0, 3'(n), 4'b0010});
      end
   endtask

   // Unmapped places and a disabled lane must leave storage alone
   task automatic t_refuse;
      logic [1:0]  resp;
      logic [31:0] rd;
      axi_write(9'h150, 8'h11, 4'h1, resp);
      chk("unmapped wresp", 32'(resp), 32'(RESP_SLVERR));
      axi_read(9'h150, rd, resp);
      chk("unmapped rresp", 32'(resp), 32'(RESP_SLVERR));
      chk("unmapped rdata", rd, 32'h0);
      axi_read(9'h000, rd, resp);
      chk("low rresp", 32'(resp), 32'(RESP_SLVERR));
      axi_write(9'h134, 8'h00, 4'he, resp);
      chk("lane off wresp", 32'(resp), 32'(RESP_OKAY));
      axi_read(9'h134, rd, resp);
      chk("lane off keeps", rd, 32'h96);
      chk("integer kept", 32'(cfg.div4_integer_param), 32'h29669);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic conclude;
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      conclude;
   end

   initial begin
      err_total   = 0;
      comparisons = 0;
      aresetn     = 1'b0;
      awaddr      = '0;
      awvalid     = 1'b0;
      wdata       = '0;
      wstrb       = '0;
      wvalid      = 1'b0;
      bready      = 1'b0;
      araddr      = '0;
      arvalid     = 1'b0;
      rready      = 1'b0;
      do_reset;
      t_map;
      t_post;
      t_refuse;
      // Mid-run reset must clear the programmed fields again
      do_reset;
      conclude;
   end
endmodule
